// >>> src/rsiv_map.svh
// Constants for the reset-state and interrupt vectoring block.
// Assumes inclusion by bare name from the src folder.
`ifndef RSIV_MAP_SVH
`define RSIV_MAP_SVH
`define RSIV_PC_W          13
`define RSIV_RESET_VEC     13'h0000
`define RSIV_IRQ_VEC       13'h0004
`define RSIV_STAT_TO       4
`define RSIV_STAT_PD       3
`define RSIV_STAT_POR      8'h18
`define RSIV_POWER_CONTROL_REG_POR      1
`define RSIV_POWER_CONTROL_REG_BOR      0
`define RSIV_PORTA_W       6
`define RSIV_PORTB_W       8
`define RSIV_CORE_SRC      3
`define RSIV_PERIPH_SRC    4
`define RSIV_LAT_MIN       3
`define RSIV_LAT_MAX       4
`endif

// >>> src/rsiv_pkg.sv
// Types for the reset-state and interrupt vectoring block.
// Assumes rsiv_map.svh is on the include path.
package rsiv_pkg;
  typedef enum logic [2:0] {
    RSIV_RST_NONE,
    RSIV_RST_POR,
    RSIV_RST_BOR,
    RSIV_RST_MASTER_CLEAR_PIN,
    RSIV_RST_WDT
  } rsiv_reset_type;
  typedef enum logic [1:0] {
    RSIV_IDLE,
    RSIV_SYNC,
    RSIV_DISPATCH
  } rsiv_irq_state_type;
endpackage

// >>> src/rsiv_flags.sv
// Sticky interrupt flag register with per-bit set and clear.
// Assumes events and software clears are synchronous to mclk.
`timescale 1ns/10ps
module rsiv_flags #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             sync_clr,
  input  wire logic [WIDTH-1:0] set_evt,
  input  wire logic [WIDTH-1:0] clr_req,
  output logic      [WIDTH-1:0] flags_q
);
  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= '0;
    end else if (clk_en) begin
      if (sync_clr) begin
        flags_q <= set_evt;
      end else begin
        flags_q <= (flags_q & ~clr_req) | set_evt;
      end
    end
  end
endmodule // rsiv_flags

// >>> src/rsiv_core.sv
// Core exception logic: reset state, wake-up and interrupt vectoring.
// Assumes sequencer, sources and reset causes are synchronous to mclk.
`timescale 1ns/10ps
`include "rsiv_map.svh"
module rsiv_core #(
  parameter int PC_W = `RSIV_PC_W,
  parameter int NP   = `RSIV_PERIPH_SRC,
  parameter int PA_W = `RSIV_PORTA_W,
  parameter int PB_W = `RSIV_PORTB_W
) (
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  input  wire logic                           clk_en,
  input  wire logic                           brownout_detect_cfg,
  input  wire logic                           por_evt,
  input  wire logic                           bor_evt,
  input  wire logic                           master_clear_pin_evt,
  input  wire logic                           watchdog_timeout,
  input  wire logic                           sleeping,
  input  wire logic                           cycle_strobe,
  input  wire logic [PC_W-1:0]                pc_in,
  input  wire logic                           return_from_irq_instr,
  input  wire logic [PC_W-1:0]                stack_top,
  input  wire logic                           ext_irq_evt,
  input  wire logic                           port_change_evt,
  input  wire logic                           timer_zero_ovf,
  input  wire logic [NP-1:0]                  periph_evt,
  input  wire logic [`RSIV_CORE_SRC-1:0]      core_en_in,
  input  wire logic                           periph_gate_in,
  input  wire logic                           cfg_we,
  input  wire logic [NP-1:0]                  periph_enable_in,
  input  wire logic [`RSIV_CORE_SRC-1:0]      core_flag_clr,
  input  wire logic [NP-1:0]                  periph_flag_clr,
  input  wire logic                           por_flag_set,
  input  wire logic                           bor_flag_set,
  output logic      [PC_W-1:0]                pc_load_q,
  output logic                                pc_load_valid_q,
  output logic                                stack_push_q,
  output logic      [PC_W-1:0]                push_addr_q,
  output logic                                stack_pop_q,
  output logic                                global_irq_enable_q,
  output logic      [`RSIV_CORE_SRC-1:0]      core_irq_flag_q,
  output logic      [`RSIV_CORE_SRC-1:0]      core_irq_en_q,
  output logic                                periph_gate_q,
  output logic      [NP-1:0]                  periph_flag_reg_a_q,
  output logic      [NP-1:0]                  periph_enable_reg_a_q,
  output logic      [7:0]                     status_q,
  output logic      [1:0]                     power_control_reg_q,
  output logic      [PA_W-1:0]                port_a_dir_q,
  output logic      [PB_W-1:0]                port_b_dir_q,
  output logic      [PA_W-1:0]                analog_pin_read_q,
  output logic                                wake_q
);
  localparam int NS = `RSIV_CORE_SRC + NP;
  rsiv_pkg::rsiv_reset_type     rst_kind;
  rsiv_pkg::rsiv_irq_state_type irq_st_q;
  logic                         any_rst;
  logic [NP-1:0]                pflags;
  logic [`RSIV_CORE_SRC-1:0]    cflags;
  logic                         irq_req;
  logic                         wake_evt;
  logic [`RSIV_CORE_SRC-1:0]    core_set;
  logic [1:0]                   lat_cnt_q;

  function automatic rsiv_pkg::rsiv_reset_type decode_reset(input logic p, input logic b,
                                                            input logic m, input logic w, input logic s);
    if (p) return rsiv_pkg::RSIV_RST_POR;
    if (b) return rsiv_pkg::RSIV_RST_BOR;
    if (m) return rsiv_pkg::RSIV_RST_MASTER_CLEAR_PIN;
    if (w && !s) return rsiv_pkg::RSIV_RST_WDT;
    return rsiv_pkg::RSIV_RST_NONE;
  endfunction

  assign rst_kind = decode_reset(por_evt, bor_evt, master_clear_pin_evt, watchdog_timeout, sleeping);
  assign any_rst  = rst_kind != rsiv_pkg::RSIV_RST_NONE;
  assign core_set = {timer_zero_ovf, port_change_evt, ext_irq_evt};
  // Flag plus enable, peripherals behind their common gate
  assign irq_req  = |(cflags & core_irq_en_q) | (periph_gate_q & |(pflags & periph_enable_reg_a_q));
  // Wake ignores the global enable; only vectoring needs it. A watchdog time-out in sleep also wakes
  assign wake_evt = sleeping && (irq_req || watchdog_timeout) && !any_rst;

  // Seven sources: three core plus four peripheral flag registers
  rsiv_flags #(.WIDTH(`RSIV_CORE_SRC)) u_core_flags (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .sync_clr(any_rst),
    .set_evt (core_set),
    .clr_req (core_flag_clr),
    .flags_q (cflags)
  );
  rsiv_flags #(.WIDTH(NP)) u_periph_flags (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .sync_clr(any_rst),
    .set_evt (periph_evt),
    .clr_req (periph_flag_clr),
    .flags_q (pflags)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_irq_flag_q     <= '0;
      periph_flag_reg_a_q <= '0;
    end else if (clk_en) begin
      core_irq_flag_q     <= cflags;
      periph_flag_reg_a_q <= pflags;
    end
  end

  // Enables are cleared by every reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_irq_en_q         <= '0;
      periph_gate_q         <= 1'b0;
      periph_enable_reg_a_q <= '0;
    end else if (clk_en) begin
      if (any_rst) begin
        core_irq_en_q         <= '0;
        periph_gate_q         <= 1'b0;
        periph_enable_reg_a_q <= '0;
      end else if (cfg_we) begin
        core_irq_en_q         <= core_en_in;
        periph_gate_q         <= periph_gate_in;
        periph_enable_reg_a_q <= periph_enable_in;
      end
    end
  end

  // Synchronise to instruction cycle boundaries: taken on the third or fourth strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st_q  <= rsiv_pkg::RSIV_IDLE;
      lat_cnt_q <= 2'h0;
    end else if (clk_en) begin
      if (any_rst) begin
        irq_st_q  <= rsiv_pkg::RSIV_IDLE;
        lat_cnt_q <= 2'h0;
      end else begin
        unique case (irq_st_q)
          rsiv_pkg::RSIV_IDLE: begin
            if (global_irq_enable_q && irq_req && !sleeping) begin
              irq_st_q  <= rsiv_pkg::RSIV_SYNC;
              lat_cnt_q <= 2'h0;
            end
          end
          rsiv_pkg::RSIV_SYNC: begin
            // Counts strobes only, so one- and two-cycle instructions match
            if (cycle_strobe) begin
              lat_cnt_q <= lat_cnt_q + 2'h1;
              if (lat_cnt_q == 2'(`RSIV_LAT_MIN - 1)) begin
                irq_st_q <= rsiv_pkg::RSIV_DISPATCH;
              end
            end
          end
          rsiv_pkg::RSIV_DISPATCH: begin
            irq_st_q <= rsiv_pkg::RSIV_IDLE;
          end
          default: begin
            irq_st_q <= rsiv_pkg::RSIV_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      global_irq_enable_q <= 1'b0;
    end else if (clk_en) begin
      if (any_rst || irq_st_q == rsiv_pkg::RSIV_DISPATCH || (wake_evt && irq_req && global_irq_enable_q)) begin
        global_irq_enable_q <= 1'b0;
      end else if (return_from_irq_instr) begin
        global_irq_enable_q <= 1'b1;
      end
    end
  end

  // Program counter loads, stack push and pop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_load_q       <= `RSIV_RESET_VEC;
      pc_load_valid_q <= 1'b0;
      stack_push_q    <= 1'b0;
      push_addr_q     <= '0;
      stack_pop_q     <= 1'b0;
      wake_q          <= 1'b0;
    end else if (clk_en) begin
      pc_load_valid_q <= 1'b0;
      stack_push_q    <= 1'b0;
      stack_pop_q     <= 1'b0;
      wake_q          <= 1'b0;
      if (any_rst) begin
        pc_load_q       <= `RSIV_RESET_VEC;
        pc_load_valid_q <= 1'b1;
      end else if (wake_evt) begin
        wake_q          <= 1'b1;
        pc_load_valid_q <= 1'b1;
        if (global_irq_enable_q && irq_req) begin
          pc_load_q    <= `RSIV_IRQ_VEC;
          stack_push_q <= 1'b1;
          push_addr_q  <= pc_in + PC_W'(1);
        end else begin
          pc_load_q <= pc_in + PC_W'(1);
        end
      end else if (irq_st_q == rsiv_pkg::RSIV_DISPATCH) begin
        pc_load_q       <= `RSIV_IRQ_VEC;
        pc_load_valid_q <= 1'b1;
        stack_push_q    <= 1'b1;
        push_addr_q     <= pc_in;
      end else if (return_from_irq_instr) begin
        pc_load_q       <= stack_top;
        pc_load_valid_q <= 1'b1;
        stack_pop_q     <= 1'b1;
      end
    end
  end

  // Status upper bits: TO and PD, plus bits 7:5 which resets clear; low bits belong to the ALU
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `RSIV_STAT_POR;
    end else if (clk_en) begin
      unique case (rst_kind)
        rsiv_pkg::RSIV_RST_POR: status_q <= `RSIV_STAT_POR;
        rsiv_pkg::RSIV_RST_BOR: status_q <= {3'h0, 2'h3, status_q[2:0]};
        rsiv_pkg::RSIV_RST_WDT: status_q <= {3'h0, 2'h1, status_q[2:0]};
        rsiv_pkg::RSIV_RST_MASTER_CLEAR_PIN: begin
          if (sleeping) status_q <= {3'h0, 2'h2, status_q[2:0]};
          else status_q <= {3'h0, status_q[4:0]};
        end
        rsiv_pkg::RSIV_RST_NONE: begin
          if (sleeping && watchdog_timeout) status_q <= {status_q[7:5], 2'h0, status_q[2:0]};
          else if (wake_evt) status_q <= {status_q[7:5], 2'h2, status_q[2:0]};
        end
      endcase
    end
  end

  // Power-on flag: only power-on clears it; software sets either flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_control_reg_q <= 2'h1;
    end else if (clk_en) begin
      if (por_evt) begin
        // Brownout flag undefined when detection is off; reads one here
        power_control_reg_q <= 2'h1;
      end else begin
        if (por_flag_set) power_control_reg_q[`RSIV_POWER_CONTROL_REG_POR] <= 1'b1;
        if (bor_evt && brownout_detect_cfg) power_control_reg_q[`RSIV_POWER_CONTROL_REG_BOR] <= 1'b0;
        else if (bor_flag_set) power_control_reg_q[`RSIV_POWER_CONTROL_REG_BOR] <= 1'b1;
      end
    end
  end

  // Ports: inputs after any reset, analogue pins read digitally as zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_dir_q      <= '1;
      port_b_dir_q      <= '1;
      analog_pin_read_q <= '0;
    end else if (clk_en && any_rst) begin
      port_a_dir_q      <= '1;
      port_b_dir_q      <= '1;
      analog_pin_read_q <= '0;
    end
  end

  property p_reset_vec;
    @(posedge mclk) disable iff (!arst_n) (clk_en && any_rst) |=> (pc_load_valid_q && pc_load_q == `RSIV_RESET_VEC);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset did not load zero");

  property p_gie_reset;
    @(posedge mclk) disable iff (!arst_n) (clk_en && any_rst) |=> !global_irq_enable_q;
  endproperty
  a_gie_reset: assert property (p_gie_reset) else $error("enable survived reset");

  property p_vector;
    @(posedge mclk) disable iff (!arst_n) (clk_en && irq_st_q == rsiv_pkg::RSIV_DISPATCH && !any_rst)
      |=> (stack_push_q && pc_load_q == `RSIV_IRQ_VEC && !global_irq_enable_q);
  endproperty
  a_vector: assert property (p_vector) else $error("vectoring incomplete");

  property p_return_from_irq_instr;
    @(posedge mclk) disable iff (!arst_n) (clk_en && return_from_irq_instr && !any_rst && irq_st_q != rsiv_pkg::RSIV_DISPATCH
      && !wake_evt) |=> (global_irq_enable_q && stack_pop_q);
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return did not re-enable");

  property p_no_irq_gie_off;
    @(posedge mclk) disable iff (!arst_n) (irq_st_q == rsiv_pkg::RSIV_IDLE && !global_irq_enable_q) |=>
      irq_st_q != rsiv_pkg::RSIV_SYNC;
  endproperty
  a_no_irq_gie_off: assert property (p_no_irq_gie_off) else $error("interrupt with enable off");

  property p_por_state;
    @(posedge mclk) disable iff (!arst_n) (clk_en && por_evt) |=> (status_q[7:3] == 5'h03 &&
      !power_control_reg_q[`RSIV_POWER_CONTROL_REG_POR]);
  endproperty
  a_por_state: assert property (p_por_state) else $error("power-on state wrong");

  property p_bor_flag;
    @(posedge mclk) disable iff (!arst_n) (clk_en && bor_evt && !por_evt && brownout_detect_cfg) |=>
      !power_control_reg_q[`RSIV_POWER_CONTROL_REG_BOR];
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brownout flag not cleared");

  property p_por_keep;
    @(posedge mclk) disable iff (!arst_n) (clk_en && !por_evt && power_control_reg_q[`RSIV_POWER_CONTROL_REG_POR]) |=>
      power_control_reg_q[`RSIV_POWER_CONTROL_REG_POR];
  endproperty
  a_por_keep: assert property (p_por_keep) else $error("power-on flag lost");

  property p_ports;
    @(posedge mclk) disable iff (!arst_n) (clk_en && any_rst) |=> (&port_a_dir_q && &port_b_dir_q);
  endproperty
  a_ports: assert property (p_ports) else $error("ports not inputs");
endmodule // rsiv_core

// >>> testbench/rsiv_seq_model.sv
// Partner model: instruction sequencer with a hardware stack.
// Assumes the bench drives sleeping and pc_seed; push and pop come from the block.
`timescale 1ns/10ps
module rsiv_seq_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        sleeping,
  input  wire logic [12:0] pc_seed,
  input  wire logic        stack_push_q,
  input  wire logic [12:0] push_addr_q,
  input  wire logic        stack_pop_q,
  output logic             cycle_strobe,
  output logic      [12:0] pc_in,
  output logic      [12:0] stack_top
);
  logic [1:0] phase_q;
  // The core clock stops in sleep, so no strobe and no program counter step
  assign cycle_strobe = (phase_q == 2'h3) && !sleeping;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
      pc_in <= pc_seed;
      stack_top <= 13'h0aaa;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (cycle_strobe) pc_in <= pc_in + 13'h1;
      if (stack_push_q) stack_top <= push_addr_q;
      // A popped slot no longer shows its value
      else if (stack_pop_q) stack_top <= ~stack_top;
    end
  end
endmodule // rsiv_seq_model

// >>> testbench/test_reset_state_and_interrupt_vectoring.sv
// Bench for the reset-state and interrupt vectoring block, checked against a model.
// Assumes the sequencer model and default parameters of the block.
`timescale 1ns/10ps
module test_reset_state_and_interrupt_vectoring;
  logic        mclk, arst_n, clk_en, brownout_detect_cfg, por_evt, bor_evt, master_clear_pin_evt;
  logic        watchdog_timeout, sleeping, cycle_strobe, return_from_irq_instr, ext_irq_evt, port_change_evt;
  logic        timer_zero_ovf, periph_gate_in, cfg_we, por_flag_set, bor_flag_set, m_gie;
  logic [12:0] pc_in, stack_top, pc_seed, pc_load_q, push_addr_q, pc_prev;
  logic [3:0]  periph_evt, periph_enable_in, periph_flag_clr, periph_flag_reg_a_q, periph_enable_reg_a_q, pv;
  logic [2:0]  core_en_in, core_flag_clr, core_irq_flag_q, core_irq_en_q;
  logic        pc_load_valid_q, stack_push_q, stack_pop_q, global_irq_enable_q, periph_gate_q, wake_q;
  logic [7:0]  status_q, m_status, port_b_dir_q;
  logic [1:0]  power_control_reg_q, m_power_control_reg;
  logic [5:0]  port_a_dir_q, analog_pin_read_q;
  int          fail_count, total_checks, n_strobe;
  rsiv_core rsiv_core_i (.mclk, .arst_n, .clk_en, .brownout_detect_cfg, .por_evt, .bor_evt, .master_clear_pin_evt,
    .watchdog_timeout, .sleeping, .cycle_strobe, .pc_in, .return_from_irq_instr, .stack_top, .ext_irq_evt,
    .port_change_evt, .timer_zero_ovf, .periph_evt, .core_en_in, .periph_gate_in, .cfg_we, .periph_enable_in,
    .core_flag_clr, .periph_flag_clr, .por_flag_set, .bor_flag_set, .pc_load_q, .pc_load_valid_q, .stack_push_q,
    .push_addr_q, .stack_pop_q, .global_irq_enable_q, .core_irq_flag_q, .core_irq_en_q, .periph_gate_q,
    .periph_flag_reg_a_q, .periph_enable_reg_a_q, .status_q, .power_control_reg_q, .port_a_dir_q, .port_b_dir_q,
    .analog_pin_read_q, .wake_q);
  rsiv_seq_model rsiv_seq_model_i (.mclk, .arst_n, .sleeping, .pc_seed, .stack_push_q, .push_addr_q, .stack_pop_q,
    .cycle_strobe, .pc_in, .stack_top);
  always #4 mclk = ~mclk;
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Waits a bounded time for a program counter load; push address is the pc seen before it plus off
  task automatic chk_load(input logic [12:0] exp_pc, input logic exp_push, input logic [12:0] off);
    int i;
    n_strobe = 0;
    for (i = 0; i < 200 && pc_load_valid_q !== 1'h1; i++) begin
      pc_prev = pc_in;
      if (cycle_strobe === 1'h1) n_strobe++;
      tick();
    end
    if (i == 200) begin
      fail_count++;
      $display("mismatch at %0t: no program counter load", $time);
      print_verdict();
    end else begin
      total_checks++;
      if (pc_load_q !== exp_pc || stack_push_q !== exp_push || (exp_push && push_addr_q !== pc_prev + off)) begin
        fail_count++;
        $display("mismatch at %0t: load %h push %b addr %h", $time, pc_load_q, stack_push_q, push_addr_q);
      end
    end
  endtask
  task automatic no_load(input int n);
    repeat (n) begin
      tick();
      chk_val(pc_load_valid_q, 16'h0, "unexpected load");
    end
  endtask
  task automatic chk_state(input logic [7:0] mask);
    chk_val(status_q & mask, m_status & mask, "status");
    chk_val(power_control_reg_q, m_power_control_reg, "power control");
    chk_val(global_irq_enable_q, m_gie, "global enable");
  endtask
  task automatic cfg(input logic [2:0] ce, input logic g, input logic [3:0] pe);
    core_en_in = ce;
    periph_gate_in = g;
    periph_enable_in = pe;
    cfg_we = 1'h1;
    tick();
    cfg_we = 1'h0;
    tick();
    chk_val({core_irq_en_q, periph_gate_q, periph_enable_reg_a_q}, {ce, g, pe}, "enables");
  endtask
  task automatic ret();
    return_from_irq_instr = 1'h1;
    tick();
    return_from_irq_instr = 1'h0;
    chk_val(stack_pop_q, 16'h1, "pop");
    tick();
    m_gie = 1'h1;
    chk_val(global_irq_enable_q, m_gie, "enable after return");
  endtask
  task automatic clr(input logic [2:0] c, input logic [3:0] p);
    core_flag_clr = c;
    periph_flag_clr = p;
    tick();
    core_flag_clr = 3'h0;
    periph_flag_clr = 4'h0;
    repeat (2) tick();
    chk_val({core_irq_flag_q & c, periph_flag_reg_a_q & p}, 16'h0, "flags cleared");
  endtask
  // Reset kinds: 0/1 master clear awake/asleep, 2/3 watchdog awake/asleep, 4 brownout, 5/6 power-on
  task automatic rst(input int k);
    brownout_detect_cfg = (k != 5);
    sleeping = (k == 1 || k == 3);
    tick();
    {por_evt, bor_evt, master_clear_pin_evt, watchdog_timeout} = {k >= 5, k == 4, k < 2, k == 2 || k == 3};
    tick();
    {por_evt, bor_evt, master_clear_pin_evt, watchdog_timeout} = 4'h0;
    case (k)
      0: m_status[7:5] = 3'h0;
      1: m_status[7:3] = 5'h02;
      2: m_status[7:3] = 5'h01;
      3: m_status[4:3] = 2'h0;
      4: begin
        m_status[7:3] = 5'h03;
        m_power_control_reg[0] = 1'h0;
      end
      default: begin
        m_status[7:3] = 5'h03;
        m_power_control_reg = 2'h1;
      end
    endcase
    if (k != 3) m_gie = 1'h0;
    chk_load(k == 3 ? pc_in + 13'h1 : 13'h0000, 1'h0, 13'h0);
    sleeping = 1'h0;
    tick();
    chk_state(k >= 5 ? 8'hf8 : 8'hff);
    chk_val({port_a_dir_q, port_b_dir_q, analog_pin_read_q}, 32'h000fffc0, "ports");
  endtask
  initial begin
    void'($urandom(32'h79e7));
    {mclk, arst_n, por_evt, bor_evt, master_clear_pin_evt, watchdog_timeout, sleeping, return_from_irq_instr} = 8'h0;
    {ext_irq_evt, port_change_evt, timer_zero_ovf, periph_gate_in, cfg_we, por_flag_set, bor_flag_set} = 7'h0;
    {periph_evt, periph_enable_in, periph_flag_clr, core_en_in, core_flag_clr} = 18'h0;
    clk_en = 1'h1;
    brownout_detect_cfg = 1'h1;
    pc_seed = 13'($urandom);
    {fail_count, total_checks, m_gie, m_power_control_reg, m_status} = {32'h0, 32'h0, 1'h0, 2'h1, 8'h18};
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'h1;
    chk_state(8'hff);
    chk_val({port_a_dir_q, port_b_dir_q, analog_pin_read_q}, 32'h000fffc0, "ports");
    cfg(3'h7, 1'h1, 4'hf);
    ret();
    for (int i = 0; i < 3; i++) begin
      repeat ($urandom % 4) tick();
      {timer_zero_ovf, port_change_evt, ext_irq_evt} = 3'h1 << i;
      tick();
      {timer_zero_ovf, port_change_evt, ext_irq_evt} = 3'h0;
      chk_load(13'h0004, 1'h1, 13'h0);
      m_gie = 1'h0;
      chk_state(8'hff);
      if (i < 2) chk_val(n_strobe >= 3 && n_strobe <= 4, 16'h1, "latency");
      clr(3'h1 << i, 4'h0);
      ret();
    end
    cfg(3'h0, 1'h0, 4'h0);
    pv = 4'($urandom) | 4'h1;
    timer_zero_ovf = 1'h1;
    periph_evt = pv;
    tick();
    timer_zero_ovf = 1'h0;
    periph_evt = 4'h0;
    no_load(12);
    chk_val({core_irq_flag_q, periph_flag_reg_a_q}, {3'h4, pv}, "flags");
    cfg(3'h0, 1'h0, 4'hf);
    no_load(12);
    cfg(3'h0, 1'h1, 4'hf);
    chk_load(13'h0004, 1'h1, 13'h0);
    m_gie = 1'h0;
    clr(3'h4, pv);
    ret();
    cfg(3'h1, 1'h0, 4'h0);
    for (int g = 1; g >= 0; g--) begin
      sleeping = 1'h1;
      tick();
      ext_irq_evt = 1'h1;
      tick();
      ext_irq_evt = 1'h0;
      if (g) chk_load(13'h0004, 1'h1, 13'h1);
      else chk_load(pc_in + 13'h1, 1'h0, 13'h0);
      chk_val(wake_q, 16'h1, "wake");
      sleeping = 1'h0;
      {m_status[4:3], m_gie} = 3'h4;
      tick();
      chk_state(8'hff);
      chk_val(core_irq_flag_q[0], 16'h1, "wake flag");
      clr(3'h1, 4'h0);
    end
    for (int k = 0; k < 7; k++) begin
      {por_flag_set, bor_flag_set} = 2'h3;
      tick();
      {por_flag_set, bor_flag_set} = 2'h0;
      m_power_control_reg = 2'h3;
      ret();
      rst(k);
    end
    cfg(3'h1, 1'h0, 4'h0);
    ret();
    {ext_irq_evt, master_clear_pin_evt} = 2'h3;
    tick();
    {ext_irq_evt, master_clear_pin_evt} = 2'h0;
    chk_load(13'h0000, 1'h0, 13'h0);
    no_load(16);
    {m_status[7:5], m_gie} = 4'h0;
    chk_state(8'hff);
    print_verdict();
  end
endmodule // test_reset_state_and_interrupt_vectoring
